// file: include/part_id_consts.svh
`ifndef PART_ID_CONSTS_SVH
`define PART_ID_CONSTS_SVH

// Register byte offsets inside the error-record group
`define PID_OFS_WORD_ZERO   12'hFE0
`define PID_OFS_WORD_ONE    12'hFE4
`define PID_ADDR_W          12
`define PID_DATA_W          32

// Field positions in the low identification word
`define PID_W0_PART_LO      0
`define PID_W0_PART_HI      7

// Field positions in the second identification word
`define PID_W1_PART_LO      0
`define PID_W1_PART_HI      3
`define PID_W1_DES_LO       4
`define PID_W1_DES_HI       7

// Part number slices and designer code slice
`define PID_PART0_LO        0
`define PID_PART0_HI        7
`define PID_PART1_LO        8
`define PID_PART1_HI        11
`define PID_DES0_LO         0
`define PID_DES0_HI         3

// Reserved upper bits and read data reset value
`define PID_RSVD_LO         8
`define PID_RSVD_HI         31
`define PID_RDATA_RESET     32'h0000_0000

// Revision bits left over for each part number width
`define PID_REV_BITS_12     4'h8
`define PID_REV_BITS_16     4'h4

`endif

// file: include/part_id_pkg.sv
package part_id_pkg;

    // Read port sequencing, one-hot
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

    // Register selected by a decoded address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b001,
        SEL_W0   = 3'b010,
        SEL_W1   = 3'b100
    } reg_sel_t;

    typedef logic [31:0] id_word_t;

endpackage

// file: include/id_req_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries one bus request to the decoder and its selection back
interface id_req_if;
    logic [11:0]           addr;
    logic                  rd;
    logic                  wr;
    logic                  enable;
    part_id_pkg::reg_sel_t sel;

    modport requester (output addr, output rd, output wr, output enable, input sel);
    modport decoder   (input addr, input rd, input wr, input enable, output sel);
endinterface

`default_nettype wire

// file: design/id_word_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "part_id_consts.svh"

// One read-only identification byte held in the low bits of a word
module id_word_rom #(
    parameter logic [7:0] LOW_BYTE = 8'h00
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    output part_id_pkg::id_word_t  word
);
    part_id_pkg::id_word_t word_r;

    // Constant loaded at reset and held; no write path exists
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            word_r <= {24'h00_0000, LOW_BYTE};
        end
        else
        begin
            word_r <= word_r;
        end
    end

    assign word = word_r;
endmodule

`default_nettype wire

// file: design/id_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "part_id_consts.svh"

// Address decoder for the two identification words
module id_addr_decode (
    id_req_if.decoder req
);
    logic hit_w0;
    logic hit_w1;

    // Match only when the group is memory mapped
    assign hit_w0 = req.enable && (req.addr == `PID_OFS_WORD_ZERO);
    assign hit_w1 = req.enable && (req.addr == `PID_OFS_WORD_ONE);

    // Unmapped or disabled addresses select nothing
    assign req.sel = hit_w0 ? part_id_pkg::SEL_W0 :
                     hit_w1 ? part_id_pkg::SEL_W1 :
                              part_id_pkg::SEL_NONE;
endmodule

`default_nettype wire

// file: design/error_record_part_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "part_id_consts.svh"

module error_record_part_id_regs #(
    parameter bit          MMAP_GROUP    = 1'b1,
    parameter int          PART_WIDTH    = 12,
    // Arbitrary neutral identification values
    parameter logic [15:0] PART_NUMBER   = 16'h0123,
    parameter logic [6:0]  DESIGNER_CODE = 7'h2A
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             id_present,
    output logic             part_is_16bit,
    output logic      [3:0]  rev_bits_avail
);

    // Refuse part number widths the layout cannot hold
    if ((PART_WIDTH != 12) && (PART_WIDTH != 16))
    begin : g_bad_width
        $error("PART_WIDTH must be 12 or 16");
    end

    // Refuse part numbers wider than the chosen width
    if ((PART_WIDTH == 12) && (PART_NUMBER[15:12] != 4'h0))
    begin : g_bad_part
        $error("PART_NUMBER exceeds 12 bits");
    end

    // --------------------------------------------------------------
    // Field slicing
    // --------------------------------------------------------------

    logic       width_is_16;
    logic [3:0] rev_bits_cfg;

    localparam logic [7:0] PART_LOW_BYTE = PART_NUMBER[`PID_PART0_HI:`PID_PART0_LO];

    localparam logic [3:0] PART_MID_NIBBLE = PART_NUMBER[`PID_PART1_HI:`PID_PART1_LO];

    localparam logic [3:0] DES_LOW_NIBBLE = DESIGNER_CODE[`PID_DES0_HI:`PID_DES0_LO];

    localparam logic [7:0] WORD_ONE_BYTE = {DES_LOW_NIBBLE, PART_MID_NIBBLE};

    assign width_is_16  = (PART_WIDTH == 16);
    assign rev_bits_cfg = width_is_16 ? `PID_REV_BITS_16 : `PID_REV_BITS_12;

    // --------------------------------------------------------------
    // Identification words
    // --------------------------------------------------------------

    part_id_pkg::id_word_t word_zero;
    part_id_pkg::id_word_t word_one;

    // Low identification word
    id_word_rom #(
        .LOW_BYTE (PART_LOW_BYTE)
    ) u_word_zero (
        .mclk (mclk),
        .rst  (rst),
        .word (word_zero)
    );

    // Second identification word
    id_word_rom #(
        .LOW_BYTE (WORD_ONE_BYTE)
    ) u_word_one (
        .mclk (mclk),
        .rst  (rst),
        .word (word_one)
    );

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------

    id_req_if req ();

    // Present the request to the decoder
    assign req.addr   = reg_addr;
    assign req.rd     = reg_rd;
    assign req.wr     = reg_wr;
    assign req.enable = MMAP_GROUP;

    id_addr_decode u_decode (
        .req (req)
    );

    // --------------------------------------------------------------
    // Read selection
    // --------------------------------------------------------------

    logic [7:0]  sel_byte;
    logic [31:0] rdata_nxt;
    logic        rd_take;
    logic        wr_seen;

    // Byte of the selected word, zero when nothing is selected
    assign sel_byte = (req.sel == part_id_pkg::SEL_W0) ?
                          word_zero[`PID_W0_PART_HI:`PID_W0_PART_LO] :
                      (req.sel == part_id_pkg::SEL_W1) ?
                          word_one[`PID_W1_DES_HI:`PID_W1_PART_LO] :
                          8'h00;

    assign rdata_nxt = {24'h00_0000, sel_byte};

    // A read is taken on its strobe; a write strobe is only observed
    assign rd_take = reg_rd;

    assign wr_seen = reg_wr;

    // --------------------------------------------------------------
    // Read port sequencer
    // --------------------------------------------------------------

    part_id_pkg::rd_state_t rd_state_r;
    part_id_pkg::rd_state_t rd_state_nxt;

    // Data phase follows every read strobe, back to back allowed
    always_comb
    begin
        rd_state_nxt = part_id_pkg::RD_IDLE;
        case (rd_state_r)
            part_id_pkg::RD_IDLE:
            begin
                if (rd_take)
                begin
                    rd_state_nxt = part_id_pkg::RD_DATA;
                end
            end
            part_id_pkg::RD_DATA:
            begin
                if (rd_take)
                begin
                    rd_state_nxt = part_id_pkg::RD_DATA;
                end
            end
            default:
            begin
                rd_state_nxt = part_id_pkg::RD_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_state_r <= part_id_pkg::RD_IDLE;
        end
        else
        begin
            rd_state_r <= rd_state_nxt;
        end
    end

    // --------------------------------------------------------------
    // Read data register
    // --------------------------------------------------------------

    logic [31:0] reg_rdata_r;
    logic [31:0] reg_rdata_nxt;

    // Data stands only in the cycle after the strobe
    assign reg_rdata_nxt = rd_take ? rdata_nxt :
                                     `PID_RDATA_RESET;

    // Read data flop
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reg_rdata_r <= `PID_RDATA_RESET;
        end
        else
        begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // --------------------------------------------------------------
    // Configuration status
    // --------------------------------------------------------------

    logic       id_present_r;
    logic       part_is_16bit_r;
    logic [3:0] rev_bits_avail_r;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            id_present_r <= 1'b0;
        end
        else
        begin
            id_present_r <= MMAP_GROUP;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            part_is_16bit_r  <= 1'b0;
            rev_bits_avail_r <= 4'h0;
        end
        else
        begin
            part_is_16bit_r  <= width_is_16;
            rev_bits_avail_r <= rev_bits_cfg;
        end
    end

    assign id_present     = id_present_r;
    assign part_is_16bit  = part_is_16bit_r;
    assign rev_bits_avail = rev_bits_avail_r;

    // write side, upper word bits and sequencer state go nowhere
    logic unused_ok;
    assign unused_ok = &{1'b0, word_zero[`PID_RSVD_HI:`PID_RSVD_LO],
                         word_one[`PID_RSVD_HI:`PID_RSVD_LO],
                         reg_wdata, wr_seen, rd_state_r, req.rd, req.wr};

endmodule

`default_nettype wire

// file: verification/part_id_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "part_id_consts.svh"

// Watches the identification read port
module part_id_chk #(
    parameter bit          MMAP_GROUP    = 1'b1,
    parameter int          PART_WIDTH    = 12,
    // Arbitrary neutral identification values
    parameter logic [15:0] PART_NUMBER   = 16'h0123,
    parameter logic [6:0]  DESIGNER_CODE = 7'h2A
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        id_present,
    input  wire logic        part_is_16bit,
    input  wire logic [3:0]  rev_bits_avail
);
    // Words this configuration must return
    localparam logic [31:0] W0 = MMAP_GROUP ? {24'h0, PART_NUMBER[7:0]} : 32'h0;
    localparam logic [31:0] W1 = MMAP_GROUP ?
        {24'h0, DESIGNER_CODE[3:0], PART_NUMBER[11:8]} : 32'h0;
    localparam logic [3:0]  REV = (PART_WIDTH == 16) ? 4'h4 : 4'h8;

    // Read decode
    wire logic rd_w0 = reg_rd && (reg_addr == `PID_OFS_WORD_ZERO);
    wire logic rd_w1 = reg_rd && (reg_addr == `PID_OFS_WORD_ONE);
    wire logic rd_other = reg_rd && !rd_w0 && !rd_w1;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Multi-step stimuli
    sequence read_then_gap;
        reg_rd ##1 !reg_rd;
    endsequence
    sequence write_then_read0;
        reg_wr ##1 rd_w0;
    endsequence

    chk_word_zero: assert property (rd_w0 |=> reg_rdata == W0)
        else $error("word zero data wrong");
    chk_word_one: assert property (rd_w1 |=> reg_rdata == W1)
        else $error("word one data wrong");
    chk_rsvd_zero: assert property (reg_rdata[31:8] == 24'h0)
        else $error("reserved bits not zero");
    chk_unmapped_zero: assert property (rd_other |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_data_one_cycle: assert property (read_then_gap |=> reg_rdata == 32'h0)
        else $error("read data held too long");
    chk_write_ignored: assert property (write_then_read0 |=> reg_rdata == W0)
        else $error("write disturbed word zero");
    chk_group_present: assert property (!$past(rst) |-> id_present == MMAP_GROUP)
        else $error("presence flag wrong");
    chk_rev_bits: assert property (!$past(rst) |->
        part_is_16bit == (PART_WIDTH == 16) && rev_bits_avail == REV)
        else $error("revision width wrong");
endmodule

bind error_record_part_id_regs part_id_chk #(.MMAP_GROUP(MMAP_GROUP),
    .PART_WIDTH(PART_WIDTH), .PART_NUMBER(PART_NUMBER), .DESIGNER_CODE(DESIGNER_CODE))
    u_part_id_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .id_present(id_present),
    .part_is_16bit(part_is_16bit), .rev_bits_avail(rev_bits_avail));

`default_nettype wire

// file: verification/tb_error_record_part_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "part_id_consts.svh"

module tb_error_record_part_id_regs;
    // Arbitrary identification values
    localparam logic [15:0] PN = 16'h0123;
    localparam logic [6:0]  DC = 7'h2A;
    localparam logic [31:0] W0 = {24'h0, PN[7:0]};
    localparam logic [31:0] W1 = {24'h0, DC[3:0], PN[11:8]};

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] rdata_a, rdata_b, da, db;
    logic        pres_a, pres_b, wide_a, wide_b;
    logic [3:0]  rev_a, rev_b;
    int          miscompares = 0;
    int          samples_checked = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    // Mapped group, 12-bit part
    error_record_part_id_regs #(.PART_NUMBER(PN), .DESIGNER_CODE(DC))
    u_error_record_part_id_regs (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_a),
        .id_present(pres_a), .part_is_16bit(wide_a), .rev_bits_avail(rev_a));
    // Group absent, 16-bit part
    error_record_part_id_regs #(.MMAP_GROUP(1'b0), .PART_WIDTH(16),
        .PART_NUMBER(16'h4567), .DESIGNER_CODE(7'h15))
    u_error_record_part_id_regs_alt (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_b),
        .id_present(pres_b), .part_is_16bit(wide_b), .rev_bits_avail(rev_b));

    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic check_field(input string nm, input logic [3:0] e, input logic [3:0] g);
        check_word(nm, {28'h0, e}, {28'h0, g});
    endtask

    // One read, both configurations sampled
    task automatic bus_read(input logic [11:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        da = rdata_a;
        db = rdata_b;
    endtask

    task automatic bus_write(input logic [11:0] a);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= 32'hFFFF_FFFF;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic check_status;
        check_field("present a", 4'h1, {3'h0, pres_a});
        check_field("present b", 4'h0, {3'h0, pres_b});
        check_field("wide a", 4'h0, {3'h0, wide_a});
        check_field("wide b", 4'h1, {3'h0, wide_b});
        check_field("rev a", 4'h8, rev_a);
        check_field("rev b", 4'h4, rev_b);
    endtask

    task automatic test_words;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= `PID_OFS_WORD_ZERO;
        @(posedge mclk);
        reg_addr <= `PID_OFS_WORD_ONE;
        #1;
        check_word("word0", W0, rdata_a);
        check_word("word0 absent", 32'h0, rdata_b);
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check_word("word1", W1, rdata_a);
        check_word("word1 absent", 32'h0, rdata_b);
        @(posedge mclk);
        #1;
        check_word("idle data", 32'h0, rdata_a);
        $display("test_words done");
    endtask

    task automatic test_unmapped;
        logic [11:0] al [4] = '{12'hFE8, 12'hFDC, 12'hFE1, 12'h000};
        foreach (al[i])
        begin
            bus_read(al[i]);
            check_word("unmapped", 32'h0, da);
        end
        $display("test_unmapped done");
    endtask

    task automatic test_writes;
        bus_write(`PID_OFS_WORD_ZERO);
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check_word("word0 after write", W0, rdata_a);
        bus_write(`PID_OFS_WORD_ONE);
        bus_read(`PID_OFS_WORD_ONE);
        check_word("word1 after write", W1, da);
        check_status();
        $display("test_writes done");
    endtask

    task automatic test_reset_read;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check_field("present in reset", 4'h0, {3'h0, pres_a});
        check_word("data in reset", 32'h0, rdata_a);
        @(posedge mclk);
        rst <= 1'b0;
        bus_read(`PID_OFS_WORD_ONE);
        check_word("word1 after reset", W1, da);
        check_status();
        $display("test_reset_read done");
    endtask

    task automatic end_sim;
        $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check_status();
        test_words();
        test_unmapped();
        test_writes();
        test_reset_read();
        end_sim();
    end
endmodule

`default_nettype wire
